// >>> rtl/nfx_pkg.sv
// Operation
// - Negate-file op writes not(byte)+1; sets negative, overflow, carry, digit-carry, zero.
// - Result goes back to the operand's own location, never elsewhere.
// - Access bit 0 picks the fixed access bank, bank register ignored, except in the indexed case below.
// - Access bit 1 joins the bank register with the 8-bit address field.
// - Access bit 0, extended set on, field up to 95: indexed offset address.
package nfx_pkg;

    // ----------------------------------------------------------------
    // Bus and memory geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int MEM_AW = 12;
    localparam int BANK_W = 4;
    localparam int INSN_W = 16;
    localparam int PC_W = 16;
    localparam int FLAG_W = 5;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_BANK = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_BASE = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_INSN = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_MADDR = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_MDATA = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_PC = 5'h1c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_EXT_BIT = 0;
    localparam int FLAG_C = 0;
    localparam int FLAG_DIGIT_CARRY = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVERFLOW = 3;
    localparam int FLAG_N = 4;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_ILL_BIT = 9;
    localparam int ACC_BIT = 8;

    // ----------------------------------------------------------------
    // Instruction encodings and address map
    // ----------------------------------------------------------------
    localparam logic [6:0] NEG_OPC = 7'h36;
    localparam logic [INSN_W-1:0] IDLE_WORD = 16'h0000;
    localparam logic [3:0] IDLE_ALT_TOP = 4'hf;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [7:0] ACC_SPLIT_EXT = 8'h60;
    localparam logic [BANK_W-1:0] ACC_LO_PAGE = 4'h0;
    localparam logic [BANK_W-1:0] ACC_HI_PAGE = 4'hf;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
    localparam logic [MEM_AW-1:0] RST_ADDR = 12'h000;
    localparam logic [INSN_W-1:0] RST_INSN = 16'h0000;
    localparam logic [FLAG_W-1:0] RST_FLAGS = 5'h00;
    localparam logic [PC_W-1:0] RST_PC = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DECODE,
        PH_READ,
        PH_PROC,
        PH_WRITE
    } nfx_phase_t;

endpackage

// >>> rtl/nfx_core.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module nfx_core #(
    parameter int MEM_DEPTH = 4096
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Avalon-MM slave
    input wire logic [nfx_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [nfx_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [nfx_pkg::BE_W-1:0] avs_byteenable_i,
    output logic [nfx_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import nfx_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [DATA_W-1:0] be_merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [BE_W-1:0] be);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [MEM_AW-1:0] eff_addr(
        input logic [INSN_W-1:0] insn,
        input logic [BANK_W-1:0] bank,
        input logic [MEM_AW-1:0] base,
        input logic ext);
        logic [7:0] f;
        logic [7:0] split;
        f = insn[7:0];
        split = ext ? ACC_SPLIT_EXT : ACC_SPLIT;
        if (insn[ACC_BIT]) begin
            return {bank, f};
        end else if (ext && f <= INDEXED_MAX) begin
            return MEM_AW'(base + {4'h0, f});
        end else if (f >= split) begin
            return {ACC_HI_PAGE, f};
        end else begin
            return {ACC_LO_PAGE, f};
        end
    endfunction

    // Flags of not(v)+1, taken from a 9-bit sum so carries stay honest.
    function automatic logic [FLAG_W-1:0] neg_flags(input logic [7:0] v);
        logic [8:0] sum;
        logic [4:0] lo;
        logic [FLAG_W-1:0] fl;
        sum = {1'b0, ~v} + 9'h001;
        lo = {1'b0, ~v[3:0]} + 5'h01;
        fl = RST_FLAGS;
        fl[FLAG_C] = sum[8];
        fl[FLAG_DIGIT_CARRY] = lo[4];
        fl[FLAG_Z] = (sum[7:0] == 8'h00);
        fl[FLAG_OVERFLOW] = ~v[7] ^ sum[7] ? sum[7] : 1'b0;
        fl[FLAG_N] = sum[7];
        return fl;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] mem [0:MEM_DEPTH-1];
    logic ext_en_q;
    logic [BANK_W-1:0] bank_q;
    logic [MEM_AW-1:0] base_q;
    logic [INSN_W-1:0] insn_q;
    logic [FLAG_W-1:0] flags_q;
    logic illegal_q;
    logic [MEM_AW-1:0] maddr_q;
    logic [PC_W-1:0] pc_q;
    nfx_phase_t phase_q;
    logic [MEM_AW-1:0] ea_q;
    logic [7:0] opnd_q;
    logic [7:0] res_q;
    logic wait_q;
    logic [DATA_W-1:0] rdata_q;

    logic busy;
    logic is_neg;
    logic is_idle;
    logic core_we;
    logic accept;
    logic wr_fire;
    logic [DATA_W-1:0] wr_val;
    logic [DATA_W-1:0] rd_val;
    logic [7:0] rd_byte;

    assign busy = (phase_q != PH_IDLE);
    assign is_neg = (insn_q[15:9] == NEG_OPC);
    assign is_idle = (insn_q == IDLE_WORD) || (insn_q[15:12] == IDLE_ALT_TOP);
    assign core_we = (phase_q == PH_WRITE) && is_neg;
    assign rd_byte = mem[ea_q];

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Writes stall while an instruction runs, so software never races
    // the core for the memory port or the flags.
    assign accept = (avs_read_i | avs_write_i) && wait_q &&
                    !(avs_write_i && busy);
    assign wr_fire = avs_write_i && !wait_q;

    always_comb begin
        rd_val = RST_DATA;
        case (avs_address_i)
            OFF_CTRL: rd_val[CTRL_EXT_BIT] = ext_en_q;
            OFF_BANK: rd_val[BANK_W-1:0] = bank_q;
            OFF_BASE: rd_val[MEM_AW-1:0] = base_q;
            OFF_INSN: rd_val[INSN_W-1:0] = insn_q;
            OFF_STATUS: begin
                rd_val[FLAG_W-1:0] = flags_q;
                rd_val[STAT_BUSY_BIT] = busy;
                rd_val[STAT_ILL_BIT] = illegal_q;
            end
            OFF_MADDR: rd_val[MEM_AW-1:0] = maddr_q;
            OFF_MDATA: rd_val[7:0] = mem[maddr_q];
            OFF_PC: rd_val[PC_W-1:0] = pc_q;
            default: rd_val = RST_DATA;
        endcase
    end

    always_comb begin
        wr_val = be_merge(rd_val, avs_writedata_i, avs_byteenable_i);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wait_q <= 1'b1;
            rdata_q <= RST_DATA;
        end else if (!wait_q) begin
            wait_q <= 1'b1;
        end else if (accept) begin
            wait_q <= 1'b0;
            rdata_q <= avs_read_i ? rd_val : rdata_q;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ext_en_q <= 1'b0;
            bank_q <= RST_BANK;
            base_q <= RST_ADDR;
            maddr_q <= RST_ADDR;
        end else if (wr_fire) begin
            case (avs_address_i)
                OFF_CTRL: ext_en_q <= wr_val[CTRL_EXT_BIT];
                OFF_BANK: bank_q <= wr_val[BANK_W-1:0];
                OFF_BASE: base_q <= wr_val[MEM_AW-1:0];
                OFF_MADDR: maddr_q <= wr_val[MEM_AW-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Instruction cycle: decode, read, process, write
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            phase_q <= PH_IDLE;
            insn_q <= RST_INSN;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (wr_fire && avs_address_i == OFF_INSN) begin
                        insn_q <= wr_val[INSN_W-1:0];
                        phase_q <= PH_DECODE;
                    end
                end
                PH_DECODE: phase_q <= PH_READ;
                PH_READ: phase_q <= PH_PROC;
                PH_PROC: phase_q <= PH_WRITE;
                PH_WRITE: phase_q <= PH_IDLE;
                default: phase_q <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ea_q <= RST_ADDR;
            opnd_q <= RST_BYTE;
            res_q <= RST_BYTE;
        end else if (phase_q == PH_DECODE && is_neg) begin
            ea_q <= eff_addr(insn_q, bank_q, base_q, ext_en_q);
        end else if (phase_q == PH_READ && is_neg) begin
            opnd_q <= rd_byte;
        end else if (phase_q == PH_PROC && is_neg) begin
            res_q <= 8'(~opnd_q + 8'h01);
        end
    end

    // The only data-memory write port, shared with software.
    always_ff @(posedge clk_i) begin
        if (core_we) begin
            mem[ea_q] <= res_q;
        end else if (wr_fire && avs_address_i == OFF_MDATA) begin
            mem[maddr_q] <= wr_val[7:0];
        end
    end

    // Hardware updates come last so they win over a software write.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            flags_q <= RST_FLAGS;
            illegal_q <= 1'b0;
        end else begin
            if (wr_fire && avs_address_i == OFF_STATUS) begin
                flags_q <= wr_val[FLAG_W-1:0];
                // Only a written one in an enabled lane clears the bit.
                if (avs_writedata_i[STAT_ILL_BIT] &&
                    avs_byteenable_i[STAT_ILL_BIT / 8]) begin
                    illegal_q <= 1'b0;
                end
            end
            if (core_we) begin
                flags_q <= neg_flags(opnd_q);
            end
            if (phase_q == PH_WRITE && !is_neg && !is_idle) begin
                illegal_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pc_q <= RST_PC;
        end else if (phase_q == PH_WRITE) begin
            pc_q <= PC_W'(pc_q + 16'h0001);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_neg_decode;
        phase_q == PH_DECODE && is_neg;
    endsequence

    sequence s_idle_decode;
        phase_q == PH_DECODE && is_idle;
    endsequence

    chk_neg_value:
    assert property (s_neg_decode ##1 phase_q == PH_READ |->
        ##2 (core_we && res_q == 8'(~$past(rd_byte, 2) + 8'h01)))
        else $error("negated value is wrong");

    chk_neg_flags:
    assert property (core_we |=>
        flags_q[FLAG_Z] == ($past(res_q) == 8'h00) &&
        flags_q[FLAG_N] == $past(res_q[7]) &&
        flags_q[FLAG_C] == ($past(opnd_q) == 8'h00) &&
        flags_q[FLAG_DIGIT_CARRY] == ($past(opnd_q[3:0]) == 4'h0) &&
        flags_q[FLAG_OVERFLOW] == ($past(opnd_q) == 8'h80))
        else $error("flags do not match the negation");

    chk_write_home:
    assert property (core_we |=> rd_byte == $past(res_q) &&
        ea_q == $past(ea_q, 3))
        else $error("result not stored at operand location");

    chk_access_bank:
    assert property (s_neg_decode ##0 (!insn_q[ACC_BIT] &&
        !(ext_en_q && insn_q[7:0] <= INDEXED_MAX)) |=>
        ea_q[7:0] == $past(insn_q[7:0]) &&
        (ea_q[11:8] == ACC_LO_PAGE || ea_q[11:8] == ACC_HI_PAGE))
        else $error("access bank address is wrong");

    chk_bank_select:
    assert property (s_neg_decode ##0 insn_q[ACC_BIT] |=>
        ea_q == {$past(bank_q), $past(insn_q[7:0])})
        else $error("bank register not applied");

    chk_indexed_mode:
    assert property (s_neg_decode ##0 (!insn_q[ACC_BIT] && ext_en_q &&
        insn_q[7:0] <= INDEXED_MAX) |=>
        ea_q == MEM_AW'($past(base_q) + {4'h0, $past(insn_q[7:0])}))
        else $error("indexed offset address is wrong");

    chk_idle_quiet:
    assert property (s_idle_decode |-> (!core_we)[*4] ##1
        (phase_q == PH_IDLE && flags_q == $past(flags_q, 4) &&
        pc_q == PC_W'($past(pc_q, 4) + 16'h0001)))
        else $error("idle op changed state or took too long");

    chk_wait_pulse:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");

    chk_write_stall:
    assert property (busy && avs_write_i && avs_waitrequest_o |=>
        avs_waitrequest_o)
        else $error("write accepted while busy");

endmodule

// >>> testbench/nfx_core_tb.sv
`timescale 1ns/1ps
module nfx_core_tb;
    import nfx_pkg::*;

    // ----------------------------------------------------------------
    // Signals, clock and the design
    // ----------------------------------------------------------------
    typedef struct {
        logic [7:0] op;
        logic a;
        logic [7:0] f;
        logic [3:0] bank;
        logic ext;
        logic [11:0] base;
        logic [11:0] addr;
    } nfx_row_t;

    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [BE_W-1:0] avs_byteenable_i = 4'hf;
    logic [DATA_W-1:0] avs_readdata_o;
    logic avs_waitrequest_o;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [PC_W-1:0] exp_pc = RST_PC;

    // The access bank splits at 80h, or at 60h with the extended set on.
    nfx_row_t rows [8] = '{
        '{8'h3a, 1'b1, 8'h20, 4'h3, 1'b0, 12'h000, 12'h320},
        '{8'h00, 1'b0, 8'h10, 4'h0, 1'b0, 12'h000, 12'h010},
        '{8'h80, 1'b0, 8'h85, 4'h2, 1'b0, 12'h000, 12'hf85},
        '{8'h01, 1'b0, 8'h5f, 4'h0, 1'b1, 12'h200, 12'h25f},
        '{8'hf0, 1'b0, 8'h60, 4'h0, 1'b1, 12'h200, 12'hf60},
        '{8'h7f, 1'b0, 8'h20, 4'h5, 1'b0, 12'h000, 12'h020},
        '{8'h10, 1'b1, 8'hff, 4'hf, 1'b0, 12'h000, 12'hfff},
        '{8'h2c, 1'b0, 8'h5f, 4'h7, 1'b0, 12'h300, 12'h05f}
    };
    logic [ADDR_W-1:0] offs [7] = '{OFF_CTRL, OFF_BANK, OFF_BASE, OFF_INSN,
                                    OFF_STATUS, OFF_MADDR, OFF_PC};

    always #10 clk_i = ~clk_i;

    nfx_core #(.MEM_DEPTH(4096)) u_nfx_core (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o)
    );

    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Values read right after the edge are those sampled at it.
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                         input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, e, q);
    endtask

    task automatic mem_put(input logic [11:0] a, input logic [7:0] v);
        wr(OFF_MADDR, {20'h0, a});
        wr(OFF_MDATA, {24'h0, v});
    endtask

    task automatic mem_chk(input logic [11:0] a, input logic [7:0] v,
                           input string what);
        wr(OFF_MADDR, {20'h0, a});
        rdchk(OFF_MDATA, {24'h0, v}, what);
    endtask

    // Polling has no limit of its own; the cycle ceiling ends a stuck run.
    task automatic run(input logic [15:0] insn);
        logic [31:0] q;
        wr(OFF_INSN, {16'h0, insn});
        do begin
            bus(1'b0, OFF_STATUS, 32'h0, q);
        end while (q[STAT_BUSY_BIT] !== 1'b0);
        exp_pc++;
    endtask

    task automatic end_of_test();
        $display("checks made %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("run stopped by the cycle ceiling");
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] res;
        logic [4:0] fl;
        repeat (20) @(posedge clk_i);
        check("waitrequest in reset", 32'h1, {31'h0, avs_waitrequest_o});
        check("readdata in reset", 32'h0, avs_readdata_o);
        reset_n_i <= 1'b1;
        foreach (offs[i]) rdchk(offs[i], 32'h0, "reset value");
        $display("test reset done");
        foreach (rows[i]) begin
            wr(OFF_CTRL, {31'h0, rows[i].ext});
            wr(OFF_BANK, {28'h0, rows[i].bank});
            wr(OFF_BASE, {20'h0, rows[i].base});
            mem_put(rows[i].addr, rows[i].op);
            wr(OFF_STATUS, 32'h0);
            run({NEG_OPC, rows[i].a, rows[i].f});
            res = ~rows[i].op + 8'h01;
            fl = {res[7], rows[i].op == 8'h80, res == 8'h00,
                  rows[i].op[3:0] == 4'h0, rows[i].op == 8'h00};
            mem_chk(rows[i].addr, res, "byte");
            rdchk(OFF_STATUS, {27'h0, fl}, "flags");
            rdchk(OFF_PC, {16'h0, exp_pc}, "count");
            $display("test negate row %0d done", i);
        end
        // The same field with the other access choice must stay untouched.
        wr(OFF_CTRL, 32'h0);
        wr(OFF_BANK, 32'h5);
        mem_put(12'h020, 8'haa);
        mem_put(12'h520, 8'h05);
        run({NEG_OPC, 1'b1, 8'h20});
        mem_chk(12'h520, 8'hfb, "banked byte");
        mem_chk(12'h020, 8'haa, "access bank byte");
        $display("test bank choice done");
        // Second op is issued while the first runs; waitrequest holds it.
        wr(OFF_BANK, 32'h3);
        mem_put(12'h321, 8'h7f);
        wr(OFF_INSN, {16'h0, NEG_OPC, 1'b1, 8'h21});
        exp_pc++;
        run({NEG_OPC, 1'b1, 8'h21});
        mem_chk(12'h321, 8'h7f, "double negate");
        rdchk(OFF_STATUS, 32'h0, "flags after 81h");
        rdchk(OFF_PC, {16'h0, exp_pc}, "count");
        $display("test back to back done");
        mem_put(12'h123, 8'h55);
        wr(OFF_STATUS, 32'h1b);
        run(IDLE_WORD);
        run({IDLE_ALT_TOP, 12'h3a5});
        mem_chk(12'h123, 8'h55, "byte after idle");
        rdchk(OFF_STATUS, 32'h1b, "flags after idle");
        rdchk(OFF_PC, {16'h0, exp_pc}, "count after idle");
        $display("test idle done");
        // An unknown word only counts and raises the sticky bit.
        run(16'h1234);
        rdchk(OFF_STATUS, 32'h21b, "unknown word status");
        wr(OFF_STATUS, 32'h200);
        rdchk(OFF_STATUS, 32'h0, "status after clear");
        // A narrow write must leave the other byte lanes alone.
        wr(OFF_BASE, 32'habc);
        avs_byteenable_i <= 4'h2;
        wr(OFF_BASE, 32'h500);
        avs_byteenable_i <= 4'hf;
        rdchk(OFF_BASE, 32'h5bc, "base after lane write");
        $display("test odd cases done");
        // Reset in mid-instruction leaves memory but clears the registers.
        wr(OFF_INSN, {16'h0, NEG_OPC, 1'b1, 8'h21});
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdchk(OFF_PC, 32'h0, "count after reset");
        rdchk(OFF_STATUS, 32'h0, "status after reset");
        mem_chk(12'h321, 8'h7f, "byte after cut op");
        $display("test mid-run reset done");
        end_of_test();
    end

endmodule
